//--- hw/fbsp_consts.svh
// Constants for the flexible bandwidth serial port.
// Assumes inclusion by bare name from files under hw/.
`ifndef FBSP_CONSTS_SVH
`define FBSP_CONSTS_SVH
`define FBSP_MODE_FRAMER 2'h0
`define FBSP_MODE_LINE 2'h1
`define FBSP_MODE_SIX 2'h2
`define FBSP_MODE_AUX 2'h3
`define FBSP_MAX_LINK_MHZ 51.84
`define FBSP_REQ_LATENCY_MAX 16
`define FBSP_CORE_PERIOD_NS 20
`endif

//--- hw/fbsp_pkg.sv
// Types imported by both ends of the flexible bandwidth serial port.
// Assumes fbsp_consts.svh is on the include path.
package fbsp_pkg;
    // Payload mode pin setting
    typedef logic [1:0] fbsp_mode_type;
    // Request latency counter
    typedef logic [4:0] fbsp_lat_type;
endpackage

//--- hw/fbsp_if.sv
// Link between the device end and the external processing end.
// One channel; the bench instantiates a single one.
`timescale 1ns/1ps
interface fbsp_if;
    logic ingress_flex_clock; // Ingress link clock, from external end
    logic ingress_flex_data; // Ingress serial bit
    logic ingress_flex_valid; // Ingress bit qualifier
    logic egress_flex_clock; // Egress link clock, from external end
    logic egress_flex_request; // One-bit request
    logic egress_flex_data; // Egress serial bit
    logic egress_flex_valid; // Egress bit qualifier
    modport device (
        input ingress_flex_clock, ingress_flex_data, ingress_flex_valid,
        input egress_flex_clock, egress_flex_request,
        output egress_flex_data, egress_flex_valid
    );
    modport ext (
        output ingress_flex_clock, ingress_flex_data, ingress_flex_valid,
        output egress_flex_clock, egress_flex_request,
        input egress_flex_data, egress_flex_valid
    );
endinterface

//--- hw/fbsp_device.sv
// Contract
// R1: Ingress clock at most 51.84 MHz, gappable.
// R2: Egress clock at most 51.84 MHz, gappable.
// R3: Ingress bits become receive payload.
// R4: Ingress bit taken only when valid high.
// R5: Valid and data sampled on ingress edge.
// R6: Mode 00 leaves the port unused.
// R7: Mode 01 uses line-side pins. Code only enables the port; no pin muxing.
// R8: Mode 10: odd pins serve even channel. Code only enables the port; no pin muxing.
// R9: Mode 11 uses auxiliary pins. Code only enables the port; no pin muxing.
// R10: Egress edge samples request, updates outputs.
// R11: One request cycle asks one bit.
// R12: Answer within 16 cycles or drop.
// R13: Request may stay high; valid marks bits.
// R14: Egress data valid only with valid.
// R15: Transmit payload leaves as serial bits.
// R16: Dropped request keeps valid low.
//
// Device end of one channel: ingress and egress run on link clocks.
// Payload words cross from/to core_clk by toggle handshakes.
// Mode pins are static straps; modes 01, 10 and 11 all just enable the port.
`timescale 1ns/1ps
`include "fbsp_consts.svh"
module fbsp_device
    import fbsp_pkg::*;
#(
    parameter int WORD_W = 8,
    parameter int LATENCY = `FBSP_REQ_LATENCY_MAX
) (
    fbsp_if.device link,
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [1:0] payload_mode_pins,
    output logic [WORD_W-1:0] rx_word,
    output logic rx_word_valid,
    input wire logic [WORD_W-1:0] tx_word,
    input wire logic tx_word_load,
    output logic tx_word_ready
);
    // Port disabled in framer-only mode
    logic active;
    assign active = (payload_mode_pins != `FBSP_MODE_FRAMER); // R6 R7 R8 R9

    // Ingress link domain: no reset, clock may be gapped
    typedef struct packed {
        logic [WORD_W-1:0] shift;
        logic [$clog2(WORD_W+1)-1:0] cnt;
        logic [WORD_W-1:0] word;
        logic tog;
    } fbsp_ing_type;
    // Power-up value only; the link domain has no reset of its own
    fbsp_ing_type ing_r = '0;
    fbsp_ing_type ing_nxt;

    // Assemble bits, hand over full word
    always_comb begin
        ing_nxt = ing_r;
        if (active && link.ingress_flex_valid) begin // R4 R5
            ing_nxt.shift = {ing_r.shift[WORD_W-2:0], link.ingress_flex_data};
            ing_nxt.cnt = ing_r.cnt + 1'b1;
            if (int'(ing_r.cnt) == WORD_W - 1) begin // R3
                ing_nxt.word = {ing_r.shift[WORD_W-2:0],
                    link.ingress_flex_data};
                ing_nxt.tog = ~ing_r.tog;
                ing_nxt.cnt = '0;
            end
        end
    end
    // Initial value only for simulation start; no link reset exists
    always_ff @(posedge link.ingress_flex_clock) begin
        ing_r <= ing_nxt;
    end

    // Egress link domain
    typedef struct packed {
        logic [WORD_W-1:0] shift;
        logic [$clog2(WORD_W+1)-1:0] left;
        logic ack;
        logic [1:0] ld_sync;
        logic pend;
        fbsp_lat_type lat;
        logic dat;
        logic vld;
    } fbsp_egr_type;
    // Power-up value only; keeps ack and counters known from the start
    fbsp_egr_type egr_r = '0;
    fbsp_egr_type egr_nxt;

    // Core domain
    typedef struct packed {
        logic [2:0] rx_sync;
        logic [WORD_W-1:0] rx_word;
        logic rx_vld;
        logic [WORD_W-1:0] tx_hold;
        logic tx_tog;
        logic [2:0] ack_sync;
        logic tx_rdy;
    } fbsp_core_type;
    fbsp_core_type core_r, core_nxt;

    // Egress: one bit per request, answered within LATENCY edges or dropped
    always_comb begin
        egr_nxt = egr_r;
        egr_nxt.ld_sync = {egr_r.ld_sync[0], core_r.tx_tog};
        egr_nxt.vld = 1'b0; // R14 R16
        egr_nxt.dat = 1'b0;
        if (egr_r.left == '0 && egr_r.ld_sync[1] != egr_r.ack) begin
            egr_nxt.shift = core_r.tx_hold; // Stable while toggles differ
            egr_nxt.left = ($clog2(WORD_W+1))'(WORD_W);
            egr_nxt.ack = egr_r.ld_sync[1];
        end
        if (active && (link.egress_flex_request || egr_r.pend)) begin // R10
            if (egr_r.left != '0) begin
                egr_nxt.dat = egr_r.shift[WORD_W-1]; // R15
                egr_nxt.vld = 1'b1;
                egr_nxt.shift = {egr_r.shift[WORD_W-2:0], 1'b0};
                egr_nxt.left = egr_r.left - 1'b1;
                egr_nxt.pend = 1'b0;
                egr_nxt.lat = '0;
            end else if (int'(egr_r.lat) >= LATENCY - 1) begin // R12
                egr_nxt.pend = 1'b0; // R16
                egr_nxt.lat = '0;
            end else begin
                egr_nxt.pend = 1'b1;
                egr_nxt.lat = egr_r.lat + 1'b1;
            end
        end
    end
    always_ff @(posedge link.egress_flex_clock) begin
        egr_r <= egr_nxt;
    end
    assign link.egress_flex_data = egr_r.dat;
    assign link.egress_flex_valid = egr_r.vld;

    // Core: catch ingress words, hold egress word until taken
    always_comb begin
        core_nxt = core_r;
        core_nxt.rx_sync = {core_r.rx_sync[1:0], ing_r.tog};
        core_nxt.ack_sync = {core_r.ack_sync[1:0], egr_r.ack};
        core_nxt.rx_vld = core_r.rx_sync[2] ^ core_r.rx_sync[1];
        if (core_r.rx_sync[2] ^ core_r.rx_sync[1]) begin
            core_nxt.rx_word = ing_r.word; // Stable since toggle
        end
        if (core_r.ack_sync[2] == core_r.tx_tog && !core_r.tx_rdy) begin
            core_nxt.tx_rdy = 1'b1;
        end
        if (tx_word_load && core_r.tx_rdy) begin
            core_nxt.tx_hold = tx_word;
            core_nxt.tx_tog = ~core_r.tx_tog;
            core_nxt.tx_rdy = 1'b0;
        end
        if (sys_rst) begin
            core_nxt = '0;
            // Align to link toggle so a stale word is not re-announced
            core_nxt.rx_sync = {3{ing_r.tog}};
            core_nxt.ack_sync = {3{egr_r.ack}};
            core_nxt.tx_tog = egr_r.ack;
        end
    end
    always_ff @(posedge core_clk) begin
        core_r <= core_nxt;
    end
    assign rx_word = core_r.rx_word;
    assign rx_word_valid = core_r.rx_vld;
    assign tx_word_ready = core_r.tx_rdy;
endmodule

//--- hw/fbsp_ext.sv
// External processing end of one channel.
// Derives both link clocks from core_clk by a divider and drives them.
`timescale 1ns/1ps
`include "fbsp_consts.svh"
module fbsp_ext
    import fbsp_pkg::*;
#(
    parameter int DIV = 2
) (
    fbsp_if.ext link,
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic in_bit,
    input wire logic in_bit_valid,
    output logic in_bit_ready,
    input wire logic req_hold,
    input wire logic req_pulse,
    output logic out_bit,
    output logic out_bit_valid
);
    typedef struct packed {
        logic [7:0] div;
        logic clk;
        logic dat;
        logic vld;
        logic req;
        logic [1:0] e_dat;
        logic [1:0] e_vld;
        logic e_clk_d;
        logic o_bit;
        logic o_vld;
        logic rdy;
        logic pulse_pend;
    } fbsp_ext_type;
    fbsp_ext_type s_r, s_nxt;

    // Divided clock; link changes on falling link edge
    always_comb begin
        s_nxt = s_r;
        s_nxt.o_vld = 1'b0;
        s_nxt.rdy = 1'b0;
        s_nxt.e_dat = {s_r.e_dat[0], link.egress_flex_data};
        s_nxt.e_vld = {s_r.e_vld[0], link.egress_flex_valid};
        s_nxt.e_clk_d = s_r.clk;
        if (req_pulse) begin
            s_nxt.pulse_pend = 1'b1;
        end
        if (int'(s_r.div) >= DIV - 1) begin
            s_nxt.div = '0;
            s_nxt.clk = ~s_r.clk; // R1 R2
            if (s_r.clk) begin
                s_nxt.dat = in_bit;
                s_nxt.vld = in_bit_valid; // R4
                s_nxt.rdy = 1'b1;
                s_nxt.req = req_hold | s_r.pulse_pend | req_pulse; // R11 R13
                s_nxt.pulse_pend = 1'b0;
            end
        end else begin
            s_nxt.div = s_r.div + 1'b1;
        end
        // Outputs settle after rising edge; sample at falling point
        if (!s_r.clk && s_r.e_clk_d && s_r.e_vld[1]) begin // R14 R16
            s_nxt.o_bit = s_r.e_dat[1];
            s_nxt.o_vld = 1'b1;
        end
        if (sys_rst) begin
            s_nxt = '0;
        end
    end
    always_ff @(posedge core_clk) begin
        s_r <= s_nxt;
    end
    assign link.ingress_flex_clock = s_r.clk;
    assign link.egress_flex_clock = s_r.clk;
    assign link.ingress_flex_data = s_r.dat;
    assign link.ingress_flex_valid = s_r.vld;
    assign link.egress_flex_request = s_r.req;
    assign in_bit_ready = s_r.rdy;
    assign out_bit = s_r.o_bit;
    assign out_bit_valid = s_r.o_vld;
endmodule

//--- verif/fbsp_link_asserts.sv
// Checker on the flex port wires between the two ends.
// Assumes bench core_clk/sys_rst and ext built with DIV=2.
`timescale 1ns/1ps
module fbsp_link_asserts (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ingress_flex_clock,
    input wire logic ingress_flex_data,
    input wire logic ingress_flex_valid,
    input wire logic egress_flex_clock,
    input wire logic egress_flex_request,
    input wire logic egress_flex_data,
    input wire logic egress_flex_valid
);
    // Egress cycles since a request; no reset, link clock may stop
    logic [4:0] since_req_r = 5'h1F;
    // Saturates so a long idle never wraps into a false pass
    always_ff @(posedge egress_flex_clock) begin
        if (egress_flex_request) since_req_r <= 5'h00;
        else if (since_req_r != 5'h1F) since_req_r <= since_req_r + 5'h01;
    end
    a_ing_clk_rate: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(ingress_flex_clock) |=> ingress_flex_clock) else $error("fast ingress clock");
    a_eg_clk_rate: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(egress_flex_clock) |=> egress_flex_clock) else $error("fast egress clock");
    a_ing_data_setup: assert property (@(posedge core_clk) disable iff (sys_rst)
        $changed(ingress_flex_data) |-> !ingress_flex_clock) else $error("data moved");
    a_ing_valid_setup: assert property (@(posedge core_clk) disable iff (sys_rst)
        $changed(ingress_flex_valid) |-> !ingress_flex_clock) else $error("valid moved");
    a_req_setup: assert property (@(posedge core_clk) disable iff (sys_rst)
        $changed(egress_flex_request) |-> !egress_flex_clock) else $error("req moved");
    a_eg_valid_edge: assert property (@(posedge core_clk) disable iff (sys_rst)
        $changed(egress_flex_valid) |-> egress_flex_clock) else $error("valid off edge");
    a_eg_data_edge: assert property (@(posedge core_clk) disable iff (sys_rst)
        $changed(egress_flex_data) |-> egress_flex_clock) else $error("data off edge");
    a_answer_bound: assert property (@(posedge egress_flex_clock) disable iff (sys_rst)
        egress_flex_valid |-> since_req_r <= 5'h10) else $error("late answer");
    c_ing_bit: cover property (@(posedge ingress_flex_clock) ingress_flex_valid);
    c_eg_req: cover property (@(posedge egress_flex_clock) egress_flex_request);
    c_eg_bit: cover property (@(posedge egress_flex_clock) egress_flex_valid);
endmodule

//--- verif/flexible_bandwidth_serial_port_tb_top.sv
// Bench: device end and external end joined by one link channel.
// Assumes package, interface, both ends and the checker compile first.
`timescale 1ns/1ps
module flexible_bandwidth_serial_port_tb_top;
    import fbsp_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    fbsp_mode_type mode = 2'h1; // Strap, changed only under reset
    logic [7:0] rx_word, got;
    logic [7:0] tx_word = 8'h00;
    logic rx_word_valid, tx_word_ready, in_bit_ready, out_bit, out_bit_valid;
    logic tx_word_load = 1'b0, in_bit = 1'b0, in_bit_valid = 1'b0;
    logic req_hold = 1'b0, req_pulse = 1'b0;
    int err_total = 0, n_tests = 0, cyc = 0;
    fbsp_if link();
    fbsp_device #(.WORD_W(8), .LATENCY(16)) u_fbsp_device (.link(link),
        .core_clk(core_clk), .sys_rst(sys_rst), .payload_mode_pins(mode),
        .rx_word(rx_word), .rx_word_valid(rx_word_valid), .tx_word(tx_word),
        .tx_word_load(tx_word_load), .tx_word_ready(tx_word_ready));
    fbsp_ext #(.DIV(2)) u_fbsp_ext (.link(link), .core_clk(core_clk),
        .sys_rst(sys_rst), .in_bit(in_bit), .in_bit_valid(in_bit_valid),
        .in_bit_ready(in_bit_ready), .req_hold(req_hold),
        .req_pulse(req_pulse), .out_bit(out_bit), .out_bit_valid(out_bit_valid));
    fbsp_link_asserts u_fbsp_link_asserts (.core_clk(core_clk),
        .sys_rst(sys_rst), .ingress_flex_clock(link.ingress_flex_clock),
        .ingress_flex_data(link.ingress_flex_data),
        .ingress_flex_valid(link.ingress_flex_valid),
        .egress_flex_clock(link.egress_flex_clock),
        .egress_flex_request(link.egress_flex_request),
        .egress_flex_data(link.egress_flex_data),
        .egress_flex_valid(link.egress_flex_valid));
    initial forever #10 core_clk = ~core_clk;
    // Hang guard, far above the thousand or so cycles the tests need
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] a, input logic [7:0] e);
        n_tests++;
        if (a !== e) begin
            err_total++;
            $display("ERROR t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    // Strap is static, so every mode change goes through a reset
    task automatic do_reset(input fbsp_mode_type m);
        @(negedge core_clk);
        sys_rst = 1'b1;
        mode = m;
        repeat (6) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
    endtask
    // Bits MSB first; data turned to junk while valid is low
    task automatic t_ingress(input logic [7:0] w, input logic on);
        logic seen;
        seen = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            @(negedge core_clk);
            in_bit = w[i];
            in_bit_valid = 1'b1;
            repeat (100) begin
                @(posedge core_clk);
                #1;
                if (in_bit_ready) break;
            end
            @(negedge core_clk);
            in_bit_valid = 1'b0;
            in_bit = ~w[i];
            // Last bit: start watching at once, the word pulse is near
            if (i > 0) repeat (8) @(negedge core_clk);
        end
        repeat (60) begin
            @(posedge core_clk);
            #1;
            if (rx_word_valid) seen = 1'b1;
            if (rx_word_valid) check(rx_word, w);
        end
        check({7'h00, seen}, {7'h00, on});
        $display("ingress mode %0d done", mode);
    endtask
    // Loads one word, then pulls it bit by bit or with request held
    task automatic t_egress(input logic [7:0] w, input logic hold);
        int n;
        n = 0;
        repeat (100) if (!tx_word_ready) @(negedge core_clk);
        @(negedge core_clk);
        tx_word = w;
        tx_word_load = 1'b1;
        @(negedge core_clk);
        tx_word_load = 1'b0;
        req_hold = hold;
        for (int i = 0; i < 8; i++) begin
            if (!hold) req_pulse = 1'b1;
            @(negedge core_clk);
            req_pulse = 1'b0;
            repeat (200) begin
                @(posedge core_clk);
                #1;
                if (out_bit_valid) break;
            end
            if (out_bit_valid) n++;
            got = {got[6:0], out_bit};
            @(negedge core_clk);
        end
        req_hold = 1'b0;
        check(8'(n), 8'h08);
        check(got, w);
        $display("egress hold %0d done", hold);
    endtask
    // A request with nothing loaded must never show valid
    task automatic t_drop();
        logic seen;
        seen = 1'b0;
        @(negedge core_clk);
        req_pulse = 1'b1;
        @(negedge core_clk);
        req_pulse = 1'b0;
        repeat (150) begin
            @(posedge core_clk);
            #1;
            if (out_bit_valid) seen = 1'b1;
        end
        check({7'h00, seen}, 8'h00);
        $display("drop done");
    endtask
    initial begin
        for (int m = 0; m < 4; m++) begin
            do_reset(2'(m));
            t_ingress(8'hA5 ^ 8'(m), m != 0);
        end
        t_egress(8'h3C, 1'b0);
        t_drop();
        t_egress(8'hC3, 1'b1);
        print_verdict();
    end
endmodule
